// File: shared/grid_pkg.sv
package grid_pkg;

    // =====================================================================
    // Grid geometry
    // =====================================================================
    localparam int unsigned GRID_RECORDS     = 500;
    localparam int unsigned RECS_PER_MSG     = 50;
    localparam int unsigned MSGS_PER_SESSION = 10;
    localparam int unsigned ALIGN_BITS       = 9;
    localparam int unsigned MASK_W           = 4;
    localparam int unsigned IDX_W            = 9;
    localparam int unsigned COUNT_W          = 4;
    localparam int unsigned SEC_W            = 17;

    // Upstream block stream identification
    localparam logic [3:0] STREAM_TYPE_ID        = 4'h5;
    localparam logic [3:0] STREAM_TYPE_EXTENSION = 4'h1;

    // Time-of-day limits for the activation field
    localparam logic [4:0] MAX_HOURS   = 5'h17;
    localparam logic [5:0] MAX_MINUTES = 6'h3b;
    localparam logic [5:0] MAX_SECONDS = 6'h3b;

    // Reset values
    localparam logic [IDX_W-1:0]   IDX_RESET   = 9'h000;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 4'h0;

    // Message kinds seen on the command port
    typedef enum logic [2:0] {
        MSG_NONE     = 3'b000,
        MSG_REQUEST  = 3'b001,
        MSG_OPEN     = 3'b010,
        MSG_RECORD   = 3'b011,
        MSG_CLOSE    = 3'b100,
        MSG_ACTIVATE = 3'b101,
        MSG_ERROR    = 3'b110
    } msg_kind_t;

    // Error causes
    typedef enum logic [1:0] {
        CAUSE_NONE         = 2'b00,
        CAUSE_WRONG_COUNT  = 2'b01,
        CAUSE_NO_GRID      = 2'b10
    } cause_t;

    // A message as seen by this block (characters already decoded)
    typedef struct packed {
        msg_kind_t               kind;
        logic [RECS_PER_MSG*MASK_W-1:0] alloc;  // record 0 in the top nibble
        logic [4:0]              hours;
        logic [5:0]              minutes;
        logic [5:0]              seconds;
        cause_t                  cause;
    } msg_t;

    // Session states
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SESSION = 2'b01,
        ST_CLOSING = 2'b10
    } state_t;

endpackage : grid_pkg

// File: design/fib_grid_session_manager.sv
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Grid holds 500 records, one per frame.
// - Record zero is the frame whose count has low nine bits zero.
// - Grid is applied cyclically, wrapping after 500 frames.
// - A session holds exactly ten record messages; otherwise an error.
// - Grid stored and made eligible only after error-free close.
// - On a request, open a session or answer no-grid error.
// - Open, then ten record messages, then close.
// - Record messages sent only while a session is open.
// - Each record message carries fifty consecutive records.
// - Record is a 4-bit mask; 1 grants, 0 forbids.
// - Mask MSB belongs to the first block of the frame.
// - Mode III: four blocks, any value 0 to F.
// - Other modes: three blocks, mask LSB always zero.
// - First record of first message is the aligned frame.
// - Activate only with a valid stored grid; else error.
// - New grid takes effect at first aligned frame after the time.
// - Current grid stays active until the next activation instant.
// - Activation time is HH:MM:SS within 00-23, 00-59, 00-59.
// - A content error aborts an open session, nothing stored.
// - Wrong record count reported with its own cause.
// - Request or activate with no grid answers a no-grid error.
// - Records chosen from the ensemble frame count.

module fib_grid_session_manager
#(
    parameter int unsigned RECORDS = grid_pkg::GRID_RECORDS
)
(
    input  wire logic           clk_in,
    input  wire logic           nrst_in,
    input  wire logic           ce_in,
    // Source grid held by this side, loaded by the user
    input  wire logic           src_we_in,
    input  wire logic [8:0]     src_addr_in,
    input  wire logic [3:0]     src_mask_in,
    input  wire logic           src_valid_in,
    // Messages from the upstream side
    input  wire logic           rx_valid_in,
    input  wire grid_pkg::msg_t rx_msg_in,
    // User asks to send an activation at the given time
    input  wire logic           act_req_in,
    input  wire logic [4:0]     act_hours_in,
    input  wire logic [5:0]     act_minutes_in,
    input  wire logic [5:0]     act_seconds_in,
    // Frame timing
    input  wire logic           frame_tick_in,
    input  wire logic [8:0]     frame_count_in,
    input  wire logic [16:0]    time_sec_in,
    input  wire logic           mode_iii_in,
    // Messages to the upstream side
    output logic                tx_valid_out,
    output grid_pkg::msg_t      tx_msg_out,
    // Active grid output
    output logic [3:0]          grant_mask_out,
    output logic                grant_any_out,
    output logic [3:0]          stream_type_id_out,
    output logic [3:0]          stream_type_ext_out,
    output logic                stored_valid_out,
    output logic                session_open_out,
    output logic                act_pending_out
);

    // =====================================================================
    // Grid storage
    // =====================================================================
    // Four banks: source, pending, stored and active.
    // A separate pending bank lets an aborted transfer leave the rest intact.
    logic [3:0] pend_mem [RECORDS];
    logic [3:0] stored_mem [RECORDS];
    logic [3:0] active_mem [RECORDS];
    logic [3:0] src_mem [RECORDS];

    grid_pkg::state_t             state, next_state;
    logic [grid_pkg::COUNT_W-1:0] msg_cnt, next_msg_cnt;
    logic [8:0]                   idx, next_idx;
    logic                         stored_valid, next_stored_valid;
    logic                         act_pending, next_act_pending;
    logic [16:0]                  act_sec, next_act_sec;
    logic                         time_passed, next_time_passed;
    logic                         tx_valid, next_tx_valid;
    grid_pkg::msg_t               tx_msg, next_tx_msg;
    logic [3:0]                   grant, next_grant;
    logic                         grant_any, next_grant_any;
    logic                         swap_now;
    logic                         rec_ok;

    // Mask forced to three blocks outside mode III
    function automatic logic [3:0] legal_mask(input logic [3:0] m, input logic mode3);
        legal_mask = mode3 ? m : {m[3:1], 1'b0};
    endfunction : legal_mask

    // =====================================================================
    // Frame index
    // =====================================================================
    // Index restarts on each aligned frame and steps once per frame.
    always_comb
    begin
        next_idx = idx;
        if (frame_tick_in)
        begin
            if (frame_count_in == 9'h000)
                next_idx = 9'h000;
            else if (idx == 9'(RECORDS - 1))
                next_idx = 9'h000;
            else
                next_idx = idx + 9'h001;
        end
    end

    // Activation happens only on an aligned frame after the requested time
    assign swap_now = frame_tick_in && (frame_count_in == 9'h000)
                      && act_pending && time_passed;

    // =====================================================================
    // Session engine
    // =====================================================================
    // Record message accepted only while a transfer is open
    assign rec_ok = (state == grid_pkg::ST_SESSION) && (msg_cnt < 4'(grid_pkg::MSGS_PER_SESSION));

    always_comb
    begin
        next_state        = state;
        next_msg_cnt      = msg_cnt;
        next_stored_valid = stored_valid;
        next_act_pending  = act_pending;
        next_act_sec      = act_sec;
        next_time_passed  = time_passed;
        next_tx_valid     = 1'b0;
        next_tx_msg       = tx_msg;
        next_grant        = grant;
        // Activation instant tracking
        if (act_pending && time_sec_in >= act_sec)
            next_time_passed = 1'b1;
        if (swap_now)
            next_act_pending = 1'b0;
        case (state)
            grid_pkg::ST_IDLE:
            begin
                if (rx_valid_in && rx_msg_in.kind == grid_pkg::MSG_REQUEST)
                begin
                    next_tx_valid = 1'b1;
                    if (src_valid_in)
                    begin
                        next_tx_msg.kind = grid_pkg::MSG_OPEN;
                        next_state       = grid_pkg::ST_SESSION;
                        next_msg_cnt     = grid_pkg::COUNT_RESET;
                    end
                    else
                    begin
                        next_tx_msg.kind  = grid_pkg::MSG_ERROR;
                        next_tx_msg.cause = grid_pkg::CAUSE_NO_GRID;
                    end
                end
                else if (act_req_in)
                begin
                    next_tx_valid = 1'b1;
                    if (stored_valid && act_hours_in <= grid_pkg::MAX_HOURS
                        && act_minutes_in <= grid_pkg::MAX_MINUTES
                        && act_seconds_in <= grid_pkg::MAX_SECONDS)
                    begin
                        next_tx_msg.kind    = grid_pkg::MSG_ACTIVATE;
                        next_tx_msg.hours   = act_hours_in;
                        next_tx_msg.minutes = act_minutes_in;
                        next_tx_msg.seconds = act_seconds_in;
                        next_act_pending    = 1'b1;
                        next_time_passed    = 1'b0;
                        next_act_sec        = 17'(act_hours_in * 3600)
                                              + 17'(act_minutes_in * 60) + 17'(act_seconds_in);
                    end
                    else
                    begin
                        next_tx_msg.kind  = grid_pkg::MSG_ERROR;
                        next_tx_msg.cause = grid_pkg::CAUSE_NO_GRID;
                    end
                end
                else if (rx_valid_in && rx_msg_in.kind == grid_pkg::MSG_ERROR)
                    next_act_pending = 1'b0;    // Upstream refused the activation
            end
            grid_pkg::ST_SESSION:
            begin
                if (rx_valid_in && rx_msg_in.kind == grid_pkg::MSG_ERROR)
                    next_state = grid_pkg::ST_IDLE;
                else if (rec_ok)
                begin
                    // One record message per cycle, fifty records each
                    next_tx_valid = 1'b1;
                    next_tx_msg.kind = grid_pkg::MSG_RECORD;
                    for (int i = 0; i < 50; i++)
                        next_tx_msg.alloc[199-4*i -: 4] =
                            legal_mask(src_mem[int'(msg_cnt) * 50 + i], mode_iii_in);
                    next_msg_cnt = msg_cnt + 4'h1;
                end
                else
                    next_state = grid_pkg::ST_CLOSING;
            end
            grid_pkg::ST_CLOSING:
            begin
                next_tx_valid = 1'b1;
                next_state    = grid_pkg::ST_IDLE;
                if (msg_cnt == 4'(grid_pkg::MSGS_PER_SESSION))
                begin
                    next_tx_msg.kind  = grid_pkg::MSG_CLOSE;
                    next_stored_valid = 1'b1;
                end
                else
                begin
                    next_tx_msg.kind  = grid_pkg::MSG_ERROR;
                    next_tx_msg.cause = grid_pkg::CAUSE_WRONG_COUNT;
                end
            end
            default:
                next_state = grid_pkg::ST_IDLE;
        endcase
        // Grant for the frame now starting
        if (frame_tick_in)
            next_grant = legal_mask(swap_now ? stored_mem[0] : active_mem[next_idx], mode_iii_in);
        next_grant_any = |next_grant;
    end

    // =====================================================================
    // Registers
    // =====================================================================
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state        <= grid_pkg::ST_IDLE;
            msg_cnt      <= grid_pkg::COUNT_RESET;
            idx          <= grid_pkg::IDX_RESET;
            stored_valid <= 1'b0;
            act_pending  <= 1'b0;
            act_sec      <= 17'h0_0000;
            time_passed  <= 1'b0;
            tx_valid     <= 1'b0;
            tx_msg       <= '0;
            grant        <= 4'h0;
            grant_any    <= 1'b0;
        end
        else if (ce_in)
        begin
            state        <= next_state;
            msg_cnt      <= next_msg_cnt;
            idx          <= next_idx;
            stored_valid <= next_stored_valid;
            act_pending  <= next_act_pending;
            act_sec      <= next_act_sec;
            time_passed  <= next_time_passed;
            tx_valid     <= next_tx_valid;
            tx_msg       <= next_tx_msg;
            grant        <= next_grant;
            grant_any    <= next_grant_any;
        end
    end

    // Memory banks: source writes, pending copy per record message, swap on activation
    generate
        for (genvar g = 0; g < RECORDS; g++)
        begin : g_rec
            always_ff @(posedge clk_in)
            begin
                if (ce_in)
                begin
                    if (src_we_in && src_addr_in == 9'(g))
                        src_mem[g] <= src_mask_in;
                    if (state == grid_pkg::ST_SESSION && rec_ok
                        && int'(msg_cnt) == g / 50)
                        pend_mem[g] <= legal_mask(src_mem[g], mode_iii_in);
                    if (state == grid_pkg::ST_CLOSING && msg_cnt == 4'(grid_pkg::MSGS_PER_SESSION))
                        stored_mem[g] <= pend_mem[g];
                end
            end

            // Reset clears it: no access before a swap
            always_ff @(posedge clk_in or negedge nrst_in)
            begin
                if (!nrst_in)
                    active_mem[g] <= 4'h0;
                else if (ce_in && swap_now)
                    active_mem[g] <= stored_mem[g];
            end
        end
    endgenerate

    // =====================================================================
    // Outputs
    // =====================================================================
    assign tx_valid_out        = tx_valid;
    assign tx_msg_out          = tx_msg;
    assign grant_mask_out      = grant;
    assign grant_any_out       = grant_any;
    assign stream_type_id_out  = grid_pkg::STREAM_TYPE_ID;
    assign stream_type_ext_out = grid_pkg::STREAM_TYPE_EXTENSION;
    assign stored_valid_out    = stored_valid;
    assign session_open_out    = (state != grid_pkg::ST_IDLE);
    assign act_pending_out     = act_pending;

    // =====================================================================
    // Checks
    // =====================================================================
    property p_record_in_session;
        @(posedge clk_in) disable iff (!nrst_in)
        (tx_valid && tx_msg.kind == grid_pkg::MSG_RECORD) |-> $past(state) == grid_pkg::ST_SESSION;
    endproperty
    a_record_in_session: assert property (p_record_in_session)
        else $error("record message outside session");

    property p_close_after_ten;
        @(posedge clk_in) disable iff (!nrst_in)
        (tx_valid && tx_msg.kind == grid_pkg::MSG_CLOSE) |-> msg_cnt == 4'hA;
    endproperty
    a_close_after_ten: assert property (p_close_after_ten)
        else $error("close without ten records");

    property p_store_on_close;
        @(posedge clk_in) disable iff (!nrst_in)
        $rose(stored_valid) |-> tx_valid && tx_msg.kind == grid_pkg::MSG_CLOSE;
    endproperty
    a_store_on_close: assert property (p_store_on_close)
        else $error("grid stored without clean close");

    property p_act_needs_grid;
        @(posedge clk_in) disable iff (!nrst_in)
        (tx_valid && tx_msg.kind == grid_pkg::MSG_ACTIVATE) |-> stored_valid;
    endproperty
    a_act_needs_grid: assert property (p_act_needs_grid)
        else $error("activate without stored grid");

    property p_time_range;
        @(posedge clk_in) disable iff (!nrst_in)
        (tx_valid && tx_msg.kind == grid_pkg::MSG_ACTIVATE) |->
            tx_msg.hours <= 5'h17 && tx_msg.minutes <= 6'h3b && tx_msg.seconds <= 6'h3b;
    endproperty
    a_time_range: assert property (p_time_range)
        else $error("activation time out of range");

    property p_idx_align;
        @(posedge clk_in) disable iff (!nrst_in)
        (ce_in && frame_tick_in && frame_count_in == 9'h000) |=> idx == 9'h000;
    endproperty
    a_idx_align: assert property (p_idx_align)
        else $error("index not aligned");

    property p_idx_wrap;
        @(posedge clk_in) disable iff (!nrst_in)
        idx < 9'(RECORDS);
    endproperty
    a_idx_wrap: assert property (p_idx_wrap)
        else $error("index beyond grid");

    property p_three_blocks;
        @(posedge clk_in) disable iff (!nrst_in)
        (!mode_iii_in && ce_in && frame_tick_in) |=> grant[0] == 1'b0;
    endproperty
    a_three_blocks: assert property (p_three_blocks)
        else $error("fourth block granted outside mode three");

    sequence s_error_in;
        rx_valid_in && ce_in && rx_msg_in.kind == grid_pkg::MSG_ERROR && state == grid_pkg::ST_SESSION;
    endsequence
    property p_abort;
        @(posedge clk_in) disable iff (!nrst_in)
        s_error_in |=> state == grid_pkg::ST_IDLE && $stable(stored_valid);
    endproperty
    a_abort: assert property (p_abort)
        else $error("error did not abort session");

endmodule : fib_grid_session_manager

// File: verif/upstream_model.sv
`timescale 1ns/1ps
// ======================================================================
// Upstream entity: collects the grid sent in a session
// ======================================================================
module upstream_model
(
    input  wire logic           clk_in,
    input  wire logic           nrst_in,
    input  wire logic           tx_valid_in,
    input  wire grid_pkg::msg_t tx_msg_in,
    input  wire logic           grant_any_in,
    output logic [7:0]          rec_count_out,
    output logic [7:0]          close_count_out,
    output logic [7:0]          stray_count_out,
    output logic                stream_on_out
);
    logic [3:0] grid [0:499];
    logic       in_session;

    // Blocks are offered only in frames the grid grants
    assign stream_on_out = grant_any_in;

    // Records land in order; one outside a session is stray
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            in_session      <= 1'b0;
            rec_count_out   <= 8'h00;
            close_count_out <= 8'h00;
            stray_count_out <= 8'h00;
        end
        else if (tx_valid_in)
        begin
            case (tx_msg_in.kind)
                grid_pkg::MSG_OPEN:
                begin
                    in_session    <= 1'b1;
                    rec_count_out <= 8'h00;
                end
                grid_pkg::MSG_RECORD:
                begin
                    if (!in_session || rec_count_out > 8'd9)
                        stray_count_out <= stray_count_out + 8'h01;
                    else
                        for (int i = 0; i < 50; i++)
                            grid[rec_count_out*50+i] <= tx_msg_in.alloc[199-4*i -: 4];
                    rec_count_out <= rec_count_out + 8'h01;
                end
                grid_pkg::MSG_CLOSE:
                begin
                    in_session      <= 1'b0;
                    close_count_out <= close_count_out + 8'h01;
                end
                default:
                begin
                end
            endcase
        end
    end
endmodule : upstream_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // ======================================================================
    // Signals
    // ======================================================================
    logic           clk_in, nrst_in, src_we_in, src_valid_in, rx_valid_in, act_req_in;
    logic           frame_tick_in, mode_iii_in, tx_valid_out, grant_any_out, stored_valid_out;
    logic           session_open_out, act_pending_out, stream_on;
    logic [8:0]     src_addr_in, frame_count_in;
    logic [3:0]     src_mask_in, grant_mask_out, stream_type_id_out, stream_type_ext_out;
    logic [4:0]     act_hours_in;
    logic [5:0]     act_minutes_in, act_seconds_in;
    logic [16:0]    time_sec_in;
    logic [7:0]     rec_count, close_count, stray_count;
    grid_pkg::msg_t rx_msg_in, tx_msg_out;
    int             num_errors, num_checks, cycles, n;
    typedef struct packed { logic act; logic srcv; grid_pkg::msg_kind_t kind; grid_pkg::cause_t cause; } row_t;
    row_t           rows [0:1];

    fib_grid_session_manager dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .src_we_in(src_we_in),
        .src_addr_in(src_addr_in), .src_mask_in(src_mask_in), .src_valid_in(src_valid_in),
        .rx_valid_in(rx_valid_in), .rx_msg_in(rx_msg_in), .act_req_in(act_req_in), .act_hours_in(act_hours_in),
        .act_minutes_in(act_minutes_in), .act_seconds_in(act_seconds_in), .frame_tick_in(frame_tick_in),
        .frame_count_in(frame_count_in), .time_sec_in(time_sec_in), .mode_iii_in(mode_iii_in),
        .tx_valid_out(tx_valid_out), .tx_msg_out(tx_msg_out), .grant_mask_out(grant_mask_out),
        .grant_any_out(grant_any_out), .stream_type_id_out(stream_type_id_out),
        .stream_type_ext_out(stream_type_ext_out), .stored_valid_out(stored_valid_out),
        .session_open_out(session_open_out), .act_pending_out(act_pending_out));

    upstream_model model (.clk_in(clk_in), .nrst_in(nrst_in), .tx_valid_in(tx_valid_out), .tx_msg_in(tx_msg_out),
        .grant_any_in(grant_any_out), .rec_count_out(rec_count), .close_count_out(close_count),
        .stray_count_out(stray_count), .stream_on_out(stream_on));

    // ======================================================================
    // Helpers
    // ======================================================================
    function automatic logic [3:0] grid_val(input int i, input int s);
        return 4'((i * 7 + 3 + s) % 16);
    endfunction : grid_val

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One request, held for one taking edge
    task automatic send(input grid_pkg::msg_kind_t k, input logic act, input logic [4:0] hh);
        grid_pkg::msg_t m;
        m = '0;
        m.kind = k;
        @(posedge clk_in);
        if (act)
        begin
            act_req_in   <= 1'b1;
            act_hours_in <= hh;
        end
        else
        begin
            rx_valid_in <= 1'b1;
            rx_msg_in   <= m;
        end
        @(posedge clk_in);
        act_req_in  <= 1'b0;
        rx_valid_in <= 1'b0;
    endtask : send

    // Bounded wait for the answer
    task automatic wait_tx(output int n);
        n = 1;
        #1;
        while (tx_valid_out !== 1'b1 && n < 20)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask : wait_tx

    task automatic load_grid(input int s);
        for (int i = 0; i < 500; i++)
        begin
            @(posedge clk_in);
            src_we_in   <= 1'b1;
            src_addr_in <= 9'(i);
            src_mask_in <= grid_val(i, s);
        end
        @(posedge clk_in);
        src_we_in <= 1'b0;
    endtask : load_grid

    // Frames from count 0; late half in three-block mode
    task automatic run_frames(input int num, input logic on);
        logic [3:0] e;
        for (int j = 0; j < num; j++)
        begin
            @(posedge clk_in);
            frame_tick_in  <= 1'b1;
            frame_count_in <= 9'(j % 500);
            mode_iii_in    <= (j % 500) < 250;
            @(posedge clk_in);
            frame_tick_in <= 1'b0;
            @(posedge clk_in);
            #1;
            e = on ? grid_val(j % 500, 0) : 4'h0;
            if ((j % 500) >= 250)
                e = e & 4'he;
            chk("grant_mask", e, grant_mask_out);
            chk("grant_any", |e, grant_any_out);
        end
    endtask : run_frames

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    // ======================================================================
    // Clock, watchdog and main sequence
    // ======================================================================
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // A hang counts as a mismatch; the run needs about 2600 cycles
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            num_errors++;
            $display("ERROR watchdog expected finish seen hang");
            print_verdict();
        end
    end

    initial
    begin
        {nrst_in, src_we_in, src_valid_in, rx_valid_in, act_req_in, frame_tick_in} = '0;
        {src_addr_in, frame_count_in, src_mask_in, act_hours_in, act_minutes_in, act_seconds_in} = '0;
        rx_msg_in = '0;
        mode_iii_in = 1'b1;
        time_sec_in = 17'd3600;
        rows[0] = '{1'b0, 1'b0, grid_pkg::MSG_ERROR, grid_pkg::CAUSE_NO_GRID};
        rows[1] = '{1'b1, 1'b0, grid_pkg::MSG_ERROR, grid_pkg::CAUSE_NO_GRID};
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        #1;
        chk("stored_valid", 1'b0, stored_valid_out);
        chk("stream_type_id", grid_pkg::STREAM_TYPE_ID, stream_type_id_out);
        chk("stream_type_ext", grid_pkg::STREAM_TYPE_EXTENSION, stream_type_ext_out);
        // Requests answered while no grid is held
        foreach (rows[r])
        begin
            src_valid_in <= rows[r].srcv;
            send(rows[r].act ? grid_pkg::MSG_ACTIVATE : grid_pkg::MSG_REQUEST, rows[r].act, 5'h00);
            wait_tx(n);
            chk("answer_delay", 1, n);
            chk("answer_kind", rows[r].kind, tx_msg_out.kind);
            chk("answer_cause", rows[r].cause, tx_msg_out.cause);
        end
        $display("test no_grid done");
        // Full session; record order checked in the model
        load_grid(0);
        src_valid_in <= 1'b1;
        send(grid_pkg::MSG_REQUEST, 1'b0, 5'h00);
        wait_tx(n);
        chk("open", {32'(grid_pkg::MSG_OPEN), 32'd1}, {32'(tx_msg_out.kind), n});
        for (int k = 0; k < 10; k++)
        begin
            @(posedge clk_in);
            wait_tx(n);
            chk("record", {32'(grid_pkg::MSG_RECORD), 32'd1}, {32'(tx_msg_out.kind), n});
        end
        @(posedge clk_in);
        wait_tx(n);
        chk("close", {32'(grid_pkg::MSG_CLOSE), 32'd2}, {32'(tx_msg_out.kind), n});
        @(posedge clk_in);
        #1;
        chk("records", 8'd10, rec_count);
        chk("stray", 8'd0, stray_count);
        chk("stored_valid", 1'b1, stored_valid_out);
        for (int i = 0; i < 500; i++)
            chk("grid", grid_val(i, 0), model.grid[i]);
        $display("test session done");
        // Session aborted by an error: no close, stored grid kept
        load_grid(5);
        send(grid_pkg::MSG_REQUEST, 1'b0, 5'h00);
        repeat (3) @(posedge clk_in);
        send(grid_pkg::MSG_ERROR, 1'b0, 5'h00);
        repeat (16) @(posedge clk_in);
        #1;
        chk("abort_close", 8'd1, close_count);
        chk("abort_open", 1'b0, session_open_out);
        $display("test abort done");
        // Activation at 02:00:00 while the time is 01:00:00 waits
        send(grid_pkg::MSG_ACTIVATE, 1'b1, 5'h02);
        wait_tx(n);
        chk("act_kind", grid_pkg::MSG_ACTIVATE, tx_msg_out.kind);
        chk("act_hours", 5'h02, tx_msg_out.hours);
        chk("act_pending", 1'b1, act_pending_out);
        run_frames(3, 1'b0);
        time_sec_in <= 17'd7200;
        run_frames(506, 1'b1);
        chk("stream_on", 1'b1, stream_on);
        $display("test activation done");
        // Hour 24 is outside the time field
        send(grid_pkg::MSG_ACTIVATE, 1'b1, 5'h18);
        wait_tx(n);
        chk("bad_time", grid_pkg::MSG_ERROR, tx_msg_out.kind);
        $display("test bad_time done");
        print_verdict();
    end
endmodule : tb_top
